// ==== common/acbm_pkg.sv ====
// Purpose: Shared constants and types of the converter self-test and alert monitor.
// Assumes: 20 MHz APB clock, twelve channels, 16-bit angle words (LSB = 360/2^16 deg).
// Notes: Timing counts derive from the times and the clock rate.
package acbm_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned NCH = 12;
  localparam int unsigned SCAN_MS = 250;
  localparam int unsigned LOSS_MS = 2000;
  localparam int unsigned VERIFY_S = 30;
  localparam int unsigned STIM_S = 45;
  localparam int unsigned CAL_S = 30;
  localparam int unsigned STIM_STEPS = 72;
  localparam int unsigned SCAN_CYC = CLK_HZ / 1000 * SCAN_MS;
  localparam int unsigned VERIFY_CYC = CLK_HZ * VERIFY_S;
  localparam int unsigned STIM_DWELL_CYC = CLK_HZ / STIM_STEPS * STIM_S;
  localparam int unsigned CAL_CYC = CLK_HZ * CAL_S;
  localparam logic [3:0] LOSS_SCANS = 4'(LOSS_MS / SCAN_MS);
  localparam logic [15:0] TOL_LSB = 16'h0009;
  localparam logic [31:0] STIM_STEP = 32'h038e_38e4;
  localparam logic [6:0] SECTORS_PER_REV = 7'h48;
  localparam logic [7:0] VERIFY_MARK = 8'h55;
  // Register byte offsets
  localparam logic [11:0] OFS_TEST_EN = 12'h000;
  localparam logic [11:0] OFS_TEST_ST = 12'h004;
  localparam logic [11:0] OFS_SIG_ST = 12'h008;
  localparam logic [11:0] OFS_REF_ST = 12'h00c;
  localparam logic [11:0] OFS_ACTIVE = 12'h010;
  localparam logic [11:0] OFS_ALERT = 12'h014;
  localparam logic [11:0] OFS_VERIFY = 12'h018;
  localparam logic [11:0] OFS_TEST_ANG = 12'h01c;
  localparam logic [11:0] OFS_POWER_ON_TEST = 12'h020;
  localparam logic [11:0] OFS_OSEL0 = 12'h024;
  localparam logic [11:0] OFS_THR0 = 12'h078;
  localparam logic [11:0] OFS_ALR_INIT = 12'h0a8;
  localparam logic [11:0] OFS_INT_EN = 12'h1c4;
  localparam logic [11:0] OFS_INT_ST = 12'h1c8;
  // Field positions
  localparam int unsigned TEN_IFACE_BIT = 0;
  localparam int unsigned TEN_BG_BIT = 2;
  localparam int unsigned TEN_STIM_BIT = 3;
  localparam logic [15:0] TEN_MASK = 16'h000d;
  localparam int unsigned INT_SIG_BIT = 0;
  localparam int unsigned INT_REF_BIT = 1;
  localparam int unsigned INT_ALR_BIT = 2;
  localparam int unsigned INT_TST_BIT = 3;
  localparam int unsigned OSEL_MODE_BIT = 15;
  localparam logic [2:0] RES_CODE_MAX = 3'h4;
  // Reset values
  localparam logic [15:0] TEN_RST = 16'h0000;
  localparam logic [15:0] OSEL_RST = 16'h0004;
  localparam logic [11:0] PASS_RST = 12'hfff;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } acbm_apb_req_t;

  typedef enum logic [0:0] {
    STIM_IDLE = 1'b0,
    STIM_RUN = 1'b1
  } acbm_stim_state_t;
endpackage

// ==== core/acbm_monitor.sv ====
// Purpose: Built-in test, input monitoring, angle alerts and encoder outputs for 12 channels.
// Assumes: chan_angle and check_angle come from logic on pclk; sig_ok_pin and ref_ok_pin are async.
// Notes: APB slave, zero wait states; read data registered in the setup cycle.
`timescale 1ns/1ps
`default_nettype none
module acbm_monitor
  import acbm_pkg::*;
#(
  parameter int unsigned SCAN_CYCLES = acbm_pkg::SCAN_CYC,
  parameter int unsigned VERIFY_CYCLES = acbm_pkg::VERIFY_CYC,
  parameter int unsigned DWELL_CYCLES = acbm_pkg::STIM_DWELL_CYC,
  parameter int unsigned CAL_CYCLES = acbm_pkg::CAL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire acbm_pkg::acbm_apb_req_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [acbm_pkg::NCH-1:0][15:0] chan_angle,
  input wire logic [acbm_pkg::NCH-1:0][15:0] check_angle,
  input wire logic [acbm_pkg::NCH-1:0] sig_ok_pin,
  input wire logic [acbm_pkg::NCH-1:0] ref_ok_pin,
  input wire logic power_on_test_saved,
  output logic isolate,
  output logic drive_stim,
  output logic [15:0] stim_angle,
  output logic [15:0] test_angle,
  output logic cal_busy,
  output logic irq,
  output logic [acbm_pkg::NCH-1:0] out_a,
  output logic [acbm_pkg::NCH-1:0] out_b,
  output logic [acbm_pkg::NCH-1:0] out_c
);
  import acbm_pkg::*;

  function automatic logic [15:0] adiff(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] d;
    d = a - b;
    return d[15] ? (~d + 16'h0001) : d;
  endfunction

  logic [15:0] ten_q;
  logic [NCH-1:0] active_q;
  logic [15:0] thr_q [NCH];
  logic [15:0] base_q [NCH];
  logic [15:0] osel_q [NCH];
  logic alert_arm_q;
  logic [NCH-1:0] alert_q;
  logic [3:0] int_en_q;
  logic [3:0] int_st_q;
  logic [7:0] verify_q;
  logic [15:0] test_ang_q;
  logic power_on_test_q;
  logic boot_done_q;
  logic [31:0] cal_cnt_q;
  logic [31:0] scan_cnt_q;
  logic [31:0] ver_cnt_q;
  logic [NCH-1:0] sig_s1_q, sig_s2_q, ref_s1_q, ref_s2_q;
  logic [3:0] sig_cnt_q [NCH];
  logic [3:0] ref_cnt_q [NCH];
  logic [6:0] sector_q [NCH];
  logic [NCH-1:0] pass_q;
  logic [NCH-1:0] show_q [3];
  logic [2:0] held_q;
  acbm_stim_state_t st_q;
  logic [6:0] step_q;
  logic [31:0] dwell_q;
  logic [31:0] acc_q;
  logic [NCH-1:0] fail_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  logic wr, rd_acc, setup, scan_tick, mon_en, bg_run;
  logic stim_done, stim_ev, bg_ev, sig_ev, ref_ev, alr_ev;
  logic [NCH-1:0] bg_bad, stim_bad, alr_hit, sec_chg, sig_lost, ref_lost, fail_final;
  logic [6:0] sec_now [NCH];
  logic [NCH-1:0] live [3];
  logic [2:0] rd_st;
  logic [3:0] ev;
  logic [31:0] rd_val;
  logic hit, thr_hit, osel_hit;
  logic [3:0] thr_idx, osel_idx;

  assign setup = apb.psel & ~apb.penable;
  assign wr = apb.psel & apb.penable & apb.pwrite;
  assign rd_acc = apb.psel & apb.penable & ~apb.pwrite;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // Address decode for the per-channel blocks
  assign thr_hit = (apb.paddr >= OFS_THR0) && (apb.paddr <= OFS_THR0 + 12'(4 * (NCH - 1)))
    && (apb.paddr[1:0] == 2'b00);
  assign osel_hit = (apb.paddr >= OFS_OSEL0) && (apb.paddr <= OFS_OSEL0 + 12'(4 * (NCH - 1)))
    && (apb.paddr[1:0] == 2'b00);
  assign thr_idx = 4'((apb.paddr - OFS_THR0) >> 2);
  assign osel_idx = 4'((apb.paddr - OFS_OSEL0) >> 2);

  assign mon_en = ~ten_q[TEN_STIM_BIT] & ~ten_q[TEN_IFACE_BIT];
  assign bg_run = ten_q[TEN_BG_BIT] & mon_en;
  assign scan_tick = (scan_cnt_q == 32'(SCAN_CYCLES - 1));
  assign isolate = ten_q[TEN_STIM_BIT] | ten_q[TEN_IFACE_BIT];
  assign drive_stim = ten_q[TEN_STIM_BIT];
  assign stim_angle = acc_q[31:16];
  assign test_angle = test_ang_q;
  assign cal_busy = (cal_cnt_q != 32'h0000_0000);
  assign irq = |int_st_q;

  for (genvar g = 0; g < NCH; g++) begin : g_chan
    logic [22:0] prod;
    assign prod = 23'(chan_angle[g]) * 23'(SECTORS_PER_REV);
    assign sec_now[g] = prod[22:16];
    assign sec_chg[g] = (sec_now[g] != sector_q[g]);
    assign bg_bad[g] = adiff(chan_angle[g], check_angle[g]) > TOL_LSB;
    assign stim_bad[g] = adiff(chan_angle[g], stim_angle) > TOL_LSB;
    assign alr_hit[g] = alert_arm_q && (thr_q[g] != 16'h0000)
      && (adiff(chan_angle[g], base_q[g]) > thr_q[g]);
    assign sig_lost[g] = (sig_cnt_q[g] == LOSS_SCANS);
    assign ref_lost[g] = (ref_cnt_q[g] == LOSS_SCANS);

    // Encoder or commutation outputs
    logic [2:0] code, shift;
    logic [15:0] cnt;
    logic [2:0] pairs;
    logic [15:0] elec;
    logic [18:0] eprod;
    logic [2:0] hall;
    assign code = osel_q[g][2:0];
    assign shift = (code > RES_CODE_MAX) ? RES_CODE_MAX : code;
    assign cnt = chan_angle[g] >> shift;
    assign pairs = (code == 3'h0) ? 3'h2 : ((code == 3'h1) ? 3'h3 : 3'h4);
    assign elec = 16'(chan_angle[g] * pairs);
    assign eprod = 19'(elec) * 19'h00006;
    always_comb begin
      case (eprod[18:16])
        3'h0: hall = 3'b101;
        3'h1: hall = 3'b100;
        3'h2: hall = 3'b110;
        3'h3: hall = 3'b010;
        3'h4: hall = 3'b011;
        default: hall = 3'b001;
      endcase
    end
    logic [2:0] pins_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pins_q <= 3'b000;
      end else if (osel_q[g][OSEL_MODE_BIT]) begin
        pins_q <= hall;
      end else begin
        pins_q <= {cnt[1], cnt[1] ^ cnt[0], cnt == 16'h0000};
      end
    end
    assign out_a[g] = pins_q[2];
    assign out_b[g] = pins_q[1];
    assign out_c[g] = pins_q[0];
  end

  // Live status images, inactive channels read zero
  assign live[0] = active_q & pass_q;
  assign live[1] = active_q & ~sig_lost;
  assign live[2] = active_q & ~ref_lost;
  assign rd_st[0] = rd_acc && (apb.paddr == OFS_TEST_ST);
  assign rd_st[1] = rd_acc && (apb.paddr == OFS_SIG_ST);
  assign rd_st[2] = rd_acc && (apb.paddr == OFS_REF_ST);

  assign fail_final = fail_q | (active_q & stim_bad);
  assign stim_done = (st_q == STIM_RUN) && ten_q[TEN_STIM_BIT] && (dwell_q == 32'(DWELL_CYCLES - 1))
    && (step_q == 7'(STIM_STEPS - 1));
  assign stim_ev = stim_done & |fail_final;
  assign bg_ev = bg_run & |(active_q & sec_chg & bg_bad);
  assign sig_ev = scan_tick & mon_en & |(active_q & sig_lost);
  assign ref_ev = scan_tick & mon_en & |(active_q & ref_lost);
  assign alr_ev = |alr_hit;
  assign ev = {stim_ev | bg_ev, alr_ev, ref_ev, sig_ev};

  always_comb begin
    rd_val = 32'h0000_0000;
    hit = 1'b1;
    if (thr_hit) begin
      rd_val = {16'h0000, thr_q[thr_idx]};
    end else if (osel_hit) begin
      rd_val = {16'h0000, osel_q[osel_idx]};
    end else begin
      case (apb.paddr)
        OFS_TEST_EN: rd_val = {16'h0000, ten_q};
        OFS_TEST_ST: rd_val = {20'h00000, show_q[0]};
        OFS_SIG_ST: rd_val = {20'h00000, show_q[1]};
        OFS_REF_ST: rd_val = {20'h00000, show_q[2]};
        OFS_ACTIVE: rd_val = {20'h00000, active_q};
        OFS_ALERT: rd_val = {20'h00000, alert_q};
        OFS_VERIFY: rd_val = {24'h000000, verify_q};
        OFS_TEST_ANG: rd_val = {16'h0000, test_ang_q};
        OFS_POWER_ON_TEST: rd_val = {31'h00000000, power_on_test_q};
        OFS_ALR_INIT: rd_val = 32'h0000_0000;
        OFS_INT_EN: rd_val = {28'h0000000, int_en_q};
        OFS_INT_ST: rd_val = {28'h0000000, int_st_q};
        default: hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= apb.pwrite ? 32'h0000_0000 : rd_val;
      pslverr_q <= ~hit;
    end
  end

  // Test enable: power-on test load in the first cycle, then host write wins over stimulus completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ten_q <= TEN_RST;
      boot_done_q <= 1'b0;
      power_on_test_q <= 1'b0;
    end else begin
      boot_done_q <= 1'b1;
      if (!boot_done_q) begin
        power_on_test_q <= power_on_test_saved;
        ten_q[TEN_STIM_BIT] <= power_on_test_saved;
      end else begin
        if (wr && apb.paddr == OFS_TEST_EN) begin
          ten_q <= apb.pwdata[15:0] & TEN_MASK;
        end else if (stim_done) begin
          ten_q[TEN_STIM_BIT] <= 1'b0;
        end
        if (wr && apb.paddr == OFS_POWER_ON_TEST) begin
          power_on_test_q <= apb.pwdata[0];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= '0;
      int_en_q <= 4'h0;
      test_ang_q <= 16'h0000;
      for (int i = 0; i < NCH; i++) begin
        thr_q[i] <= 16'h0000;
        osel_q[i] <= OSEL_RST;
      end
    end else if (wr) begin
      if (apb.paddr == OFS_ACTIVE) active_q <= apb.pwdata[NCH-1:0];
      if (apb.paddr == OFS_INT_EN) int_en_q <= apb.pwdata[3:0];
      if (apb.paddr == OFS_TEST_ANG) test_ang_q <= apb.pwdata[15:0];
      if (thr_hit) thr_q[thr_idx] <= apb.pwdata[15:0];
      if (osel_hit) osel_q[osel_idx] <= apb.pwdata[15:0];
    end
  end

  // Calibration after reset, scan timer and verify marker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_cnt_q <= 32'(CAL_CYCLES);
      scan_cnt_q <= 32'h0000_0000;
      ver_cnt_q <= 32'h0000_0000;
      verify_q <= 8'h00;
    end else begin
      if (cal_cnt_q != 32'h0000_0000) cal_cnt_q <= cal_cnt_q - 32'h0000_0001;
      scan_cnt_q <= scan_tick ? 32'h0000_0000 : scan_cnt_q + 32'h0000_0001;
      if (!ten_q[TEN_BG_BIT]) begin
        ver_cnt_q <= 32'h0000_0000;
      end else if (ver_cnt_q == 32'(VERIFY_CYCLES - 1)) begin
        ver_cnt_q <= 32'h0000_0000;
      end else begin
        ver_cnt_q <= ver_cnt_q + 32'h0000_0001;
      end
      if (ten_q[TEN_BG_BIT] && ver_cnt_q == 32'(VERIFY_CYCLES - 1)) begin
        verify_q <= VERIFY_MARK;
      end else if (wr && apb.paddr == OFS_VERIFY) begin
        verify_q <= apb.pwdata[7:0];
      end
    end
  end

  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_s1_q <= '0;
      sig_s2_q <= '0;
      ref_s1_q <= '0;
      ref_s2_q <= '0;
    end else begin
      sig_s1_q <= sig_ok_pin;
      sig_s2_q <= sig_s1_q;
      ref_s1_q <= ref_ok_pin;
      ref_s2_q <= ref_s1_q;
    end
  end

  // Loss qualification in scan periods; frozen while isolated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        sig_cnt_q[i] <= 4'h0;
        ref_cnt_q[i] <= 4'h0;
      end
    end else if (scan_tick && mon_en) begin
      for (int i = 0; i < NCH; i++) begin
        if (sig_s2_q[i]) sig_cnt_q[i] <= 4'h0;
        else if (!sig_lost[i]) sig_cnt_q[i] <= sig_cnt_q[i] + 4'h1;
        if (ref_s2_q[i]) ref_cnt_q[i] <= 4'h0;
        else if (!ref_lost[i]) ref_cnt_q[i] <= ref_cnt_q[i] + 4'h1;
      end
    end
  end

  // Per-channel accuracy verdicts from background checks and stimulus sweep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pass_q <= PASS_RST;
      for (int i = 0; i < NCH; i++) sector_q[i] <= 7'h00;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        sector_q[i] <= sec_now[i];
        if (stim_done) pass_q[i] <= ~fail_final[i];
        else if (bg_run && sec_chg[i]) pass_q[i] <= ~bg_bad[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= STIM_IDLE;
      step_q <= 7'h00;
      dwell_q <= 32'h0000_0000;
      acc_q <= 32'h0000_0000;
      fail_q <= '0;
    end else begin
      case (st_q)
        STIM_IDLE: begin
          if (ten_q[TEN_STIM_BIT]) begin
            st_q <= STIM_RUN;
            step_q <= 7'h00;
            dwell_q <= 32'h0000_0000;
            acc_q <= 32'h0000_0000;
            fail_q <= '0;
          end
        end
        STIM_RUN: begin
          if (!ten_q[TEN_STIM_BIT]) begin
            st_q <= STIM_IDLE;
          end else if (dwell_q == 32'(DWELL_CYCLES - 1)) begin
            dwell_q <= 32'h0000_0000;
            fail_q <= fail_final;
            acc_q <= acc_q + STIM_STEP;
            step_q <= step_q + 7'h01;
            if (stim_done) st_q <= STIM_IDLE;
          end else begin
            dwell_q <= dwell_q + 32'h0000_0001;
          end
        end
        default: st_q <= STIM_IDLE;
      endcase
    end
  end

  // Latched status views with background refresh
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_q <= 3'b000;
      for (int k = 0; k < 3; k++) show_q[k] <= '0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (rd_st[k]) begin
          held_q[k] <= 1'b0;
        end else if (!held_q[k]) begin
          show_q[k] <= live[k];
          held_q[k] <= |(active_q & ~live[k]);
        end
      end
    end
  end

  // Angle change alerts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_arm_q <= 1'b0;
      alert_q <= '0;
      for (int i = 0; i < NCH; i++) base_q[i] <= 16'h0000;
    end else begin
      if (wr && apb.paddr == OFS_ALR_INIT) begin
        alert_arm_q <= apb.pwdata[0];
        for (int i = 0; i < NCH; i++) base_q[i] <= chan_angle[i];
      end else begin
        for (int i = 0; i < NCH; i++) begin
          if (alr_hit[i]) base_q[i] <= chan_angle[i];
        end
      end
      alert_q <= ((rd_acc && apb.paddr == OFS_ALERT) ? '0 : alert_q) | alr_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_st_q <= 4'h0;
    end else begin
      int_st_q <= ((rd_acc && apb.paddr == OFS_INT_ST) ? 4'h0 : int_st_q) | (ev & int_en_q);
    end
  end
endmodule
`default_nettype wire

// ==== verif/acbm_monitor_checker.sv ====
// Purpose: Port assertions for the converter self-test monitor.
// Assumes: Bound from the testbench top file.
// Notes: Test-enable writes drive three of the six antecedents.
`timescale 1ns/1ps
`default_nettype none
module acbm_monitor_checker
  import acbm_pkg::*;
#(
  parameter int unsigned DWELL_CYCLES = 4,
  parameter int unsigned CAL_CYCLES = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire acbm_pkg::acbm_apb_req_t apb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic isolate,
  input wire logic drive_stim,
  input wire logic [15:0] test_angle,
  input wire logic cal_busy,
  input wire logic irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam int unsigned RUN_MAX = STIM_STEPS * DWELL_CYCLES + 4;
  logic acc;
  logic wr_ten;
  logic [15:0] run_q;
  logic [15:0] since_q;
  assign acc = apb.psel && apb.penable && pready;
  assign wr_ten = acc && apb.pwrite && apb.paddr == OFS_TEST_EN;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= '0;
    end else begin
      run_q <= drive_stim ? run_q + 16'h1 : 16'h0;
    end
  end
  // Cycles since reset release, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_q <= '0;
    end else if (since_q != 16'hffff) begin
      since_q <= since_q + 16'h1;
    end
  end
  sequence s_stim_go;
    wr_ten && apb.pwdata[3:0] == 4'h8;
  endsequence
  sequence s_stim_run;
    isolate ##[0:2] drive_stim;
  endsequence
  a_stim_start: assert property (s_stim_go |=> s_stim_run)
    else $error("stimulus did not start");
  a_angle_held: assert property (!(acc && apb.pwrite && apb.paddr == OFS_TEST_ANG) |=>
    $stable(test_angle))
    else $error("test angle moved without write");
  a_stim_bounded: assert property (32'(run_q) <= RUN_MAX)
    else $error("stimulus ran too long");
  a_stim_abort: assert property (wr_ten && apb.pwdata[3:0] == 4'h0 |=> !isolate ##[0:1] !drive_stim)
    else $error("abort ignored");
  a_iface_feed: assert property (wr_ten && apb.pwdata[3:0] == 4'h1 |=> isolate ##1 (isolate && !drive_stim))
    else $error("interface test not fed");
  a_test_angle: assert property (acc && apb.pwrite && apb.paddr == OFS_TEST_ANG |=>
    test_angle == $past(apb.pwdata[15:0]))
    else $error("test angle not taken");
  a_cal_window: assert property ((since_q < CAL_CYCLES - 1) ? cal_busy :
    ((since_q > CAL_CYCLES + 1) ? !cal_busy : 1'b1))
    else $error("calibration window wrong");
  a_irq_status: assert property (acc && !apb.pwrite && apb.paddr == OFS_INT_ST && prdata[3:0] != 4'h0 |-> irq)
    else $error("status set without irq");
endmodule
`default_nettype wire

// ==== verif/acbm_chan_model.sv ====
// Purpose: Behavioural converter channels beside the monitor.
// Assumes: Ideal channels, check angle equals tracked angle.
// Notes: Isolation selects stimulus or host test angle.
`timescale 1ns/1ps
`default_nettype none
module acbm_chan_model
  import acbm_pkg::*;
(
  input wire logic isolate,
  input wire logic drive_stim,
  input wire logic [15:0] stim_angle,
  input wire logic [15:0] test_angle,
  input wire logic [acbm_pkg::NCH-1:0][15:0] ext_angle,
  input wire logic [acbm_pkg::NCH-1:0] stim_fault,
  output logic [acbm_pkg::NCH-1:0][15:0] chan_angle,
  output logic [acbm_pkg::NCH-1:0][15:0] check_angle
);
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      chan_angle[i] = drive_stim ? stim_angle + (stim_fault[i] ? 16'h0010 : 16'h0000)
        : (isolate ? test_angle : ext_angle[i]);
    end
  end
  assign check_angle = chan_angle;
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Purpose: Self-checking bench for the converter self-test monitor.
// Assumes: Shortened scan, marker, dwell and calibration counts.
// Notes: Random values come from a bench shift register.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import acbm_pkg::*;
  localparam int unsigned DWELL = 4;
  logic pclk;
  logic presetn;
  acbm_apb_req_t apb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NCH-1:0][15:0] chan_angle;
  logic [NCH-1:0][15:0] check_angle;
  logic [NCH-1:0][15:0] ext_angle;
  logic [NCH-1:0] sig_ok_pin;
  logic [NCH-1:0] ref_ok_pin;
  logic [NCH-1:0] stim_fault;
  logic [NCH-1:0] out_a, out_b, out_c;
  logic power_on_test_saved;
  logic isolate;
  logic drive_stim;
  logic [15:0] stim_angle;
  logic [15:0] test_angle;
  logic cal_busy;
  logic irq;
  logic [31:0] rd;
  logic [31:0] seed;
  logic [15:0] thr;
  logic [11:0] mask;
  logic err;
  int unsigned num_errors = 0;
  int unsigned total_checks = 0;
  int unsigned cyc = 0;
  int unsigned t0;
  acbm_monitor #(.SCAN_CYCLES(20), .VERIFY_CYCLES(50), .DWELL_CYCLES(DWELL), .CAL_CYCLES(10)) dut (
    .pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chan_angle(chan_angle), .check_angle(check_angle), .sig_ok_pin(sig_ok_pin), .ref_ok_pin(ref_ok_pin),
    .power_on_test_saved(power_on_test_saved), .isolate(isolate), .drive_stim(drive_stim), .stim_angle(stim_angle),
    .test_angle(test_angle), .cal_busy(cal_busy), .irq(irq), .out_a(out_a), .out_b(out_b), .out_c(out_c));
  acbm_chan_model chans (.isolate(isolate), .drive_stim(drive_stim), .stim_angle(stim_angle),
    .test_angle(test_angle), .ext_angle(ext_angle), .stim_fault(stim_fault), .chan_angle(chan_angle),
    .check_angle(check_angle));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] live(input logic [11:0] act, input logic [11:0] lost);
    return {20'h0, act & ~lost};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    apb.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    apb <= '0;
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic wrap_up;
    if (num_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    wrap_up();
  end
  initial begin
    apb = '0;
    presetn = 1'b0;
    power_on_test_saved = 1'b0;
    seed = 32'hbeeb3767;
    sig_ok_pin = '1;
    ref_ok_pin = '1;
    ext_angle = '0;
    stim_fault = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rchk("osel reset", OFS_OSEL0, 32'h4);
    xfer(12'hffc, 1'b0, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      xfer(OFS_OSEL0 + 12'(4 * i), 1'b1, {16'h0, seed[15], 12'h0, seed[2:0]});
      rchk("osel", OFS_OSEL0 + 12'(4 * i), {16'h0, seed[15], 12'h0, seed[2:0]});
      xfer(OFS_THR0 + 12'(4 * i), 1'b1, {16'h0, seed[31:16]});
      rchk("threshold", OFS_THR0 + 12'(4 * i), {16'h0, seed[31:16]});
    end
    // Losses on ch3 signal and ch1 reference, only signal enabled
    xfer(OFS_ACTIVE, 1'b1, 32'hfff);
    repeat (50) @(posedge pclk);
    xfer(OFS_SIG_ST, 1'b0, 32'h0);
    xfer(OFS_REF_ST, 1'b0, 32'h0);
    xfer(OFS_INT_EN, 1'b1, 32'h1);
    sig_ok_pin <= 12'hffb;
    ref_ok_pin <= 12'hffe;
    repeat (250) @(posedge pclk);
    sig_ok_pin <= '1;
    ref_ok_pin <= '1;
    repeat (60) @(posedge pclk);
    rchk("sig latched", OFS_SIG_ST, live(12'hfff, 12'h004));
    rchk("ref latched", OFS_REF_ST, live(12'hfff, 12'h001));
    rchk("int status", OFS_INT_ST, 32'h1);
    repeat (25) @(posedge pclk);
    rchk("sig refresh", OFS_SIG_ST, live(12'hfff, 12'h0));
    rchk("ref refresh", OFS_REF_ST, live(12'hfff, 12'h0));
    rchk("int cleared", OFS_INT_ST, 32'h0);
    // Interface test with signal loss hidden
    seed = lfsr(seed);
    xfer(OFS_TEST_EN, 1'b1, 32'h1);
    xfer(OFS_TEST_ANG, 1'b1, {16'h0, seed[15:0]});
    @(negedge pclk);
    chk("test angle", {16'h0, test_angle}, {16'h0, seed[15:0]});
    chk("isolate", {30'h0, isolate, drive_stim}, 32'h2);
    sig_ok_pin <= '0;
    repeat (250) @(posedge pclk);
    chk("iface angle", {16'h0, chan_angle[5]}, {16'h0, seed[15:0]});
    sig_ok_pin <= '1;
    repeat (30) @(posedge pclk);
    xfer(OFS_TEST_EN, 1'b1, 32'h0);
    repeat (30) @(posedge pclk);
    rchk("sig suspended", OFS_SIG_ST, live(12'hfff, 12'h0));
    // Angle change alert, ch2 threshold zero
    seed = lfsr(seed);
    thr = {2'b00, seed[13:0]} | 16'h1;
    xfer(OFS_INT_EN, 1'b1, 32'h4);
    xfer(OFS_THR0, 1'b1, {16'h0, thr});
    xfer(OFS_THR0 + 12'h4, 1'b1, 32'h0);
    xfer(OFS_ALR_INIT, 1'b1, 32'h1);
    ext_angle[0] <= thr + 16'h1;
    ext_angle[1] <= 16'h4000;
    ext_angle[4] <= seed[31:16];
    repeat (50) @(posedge pclk);
    chk("encoder", {29'h0, out_a[4], out_b[4], out_c[4]},
      {29'h0, seed[21], seed[21] ^ seed[20], seed[31:20] == 12'h000});
    rchk("alert", OFS_ALERT, 32'h1);
    rchk("alert int", OFS_INT_ST, 32'h4);
    xfer(OFS_ALR_INIT, 1'b1, 32'h0);
    // Background marker
    xfer(OFS_TEST_EN, 1'b1, 32'h4);
    xfer(OFS_VERIFY, 1'b1, 32'h0);
    rchk("verify cleared", OFS_VERIFY, 32'h0);
    repeat (60) @(posedge pclk);
    rchk("verify mark", OFS_VERIFY, {24'h0, VERIFY_MARK});
    xfer(OFS_TEST_EN, 1'b1, 32'h0);
    // Stimulus sweep over a random active set
    seed = lfsr(seed);
    mask = seed[11:0] | 12'h001;
    xfer(OFS_ACTIVE, 1'b1, {20'h0, mask});
    stim_fault <= 12'h001;
    xfer(OFS_INT_EN, 1'b1, 32'h8);
    t0 = cyc;
    xfer(OFS_TEST_EN, 1'b1, 32'h8);
    do xfer(OFS_TEST_EN, 1'b0, 32'h0); while (rd[3] === 1'b1 && cyc - t0 < 2000);
    chk("stim done", {31'h0, rd[3]}, 32'h0);
    chk("stim length", {31'h0, cyc - t0 >= STIM_STEPS * DWELL && cyc - t0 <= STIM_STEPS * DWELL + 16}, 32'h1);
    rchk("test status", OFS_TEST_ST, live(mask, 12'h001));
    rchk("test int", OFS_INT_ST, 32'h8);
    xfer(OFS_TEST_EN, 1'b1, 32'h8);
    repeat (20) @(posedge pclk);
    xfer(OFS_TEST_EN, 1'b1, 32'h0);
    repeat (2) @(negedge pclk);
    chk("abort", {30'h0, isolate, drive_stim}, 32'h0);
    // Reset with saved power-on test
    @(posedge pclk);
    presetn <= 1'b0;
    power_on_test_saved <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(negedge pclk);
    chk("power_on_test start", {30'h0, isolate, cal_busy}, 32'h3);
    rchk("power_on_test reg", OFS_POWER_ON_TEST, 32'h1);
    repeat (400) @(posedge pclk);
    rchk("power_on_test done", OFS_TEST_EN, 32'h0);
    wrap_up();
  end
endmodule
bind acbm_monitor acbm_monitor_checker #(.DWELL_CYCLES(DWELL_CYCLES), .CAL_CYCLES(CAL_CYCLES)) u_chk (
  .pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata), .pready(pready), .isolate(isolate),
  .drive_stim(drive_stim), .test_angle(test_angle), .cal_busy(cal_busy), .irq(irq));
`default_nettype wire
